// >>> test/bitops_core_asserts.sv
// Timing checker for the bit, shift and stack execution block.
// Assumes it is bound to bitops_core and sees only that module's ports.
`timescale 1ns/1ps
module bitops_core_chk
  import bitops_pkg::*;
(
  input wire logic CLK, // Core clock.
  input wire logic SRST, // Synchronous reset.
  input wire logic OP_VALID, // Operation offered.
  input wire bitops_pkg::op_t OP_CODE, // Operation code.
  input wire logic [bitops_pkg::REG_AW-1:0] OP_REG, // Register index.
  input wire logic [bitops_pkg::BIT_AW-1:0] OP_BIT, // Bit number.
  input wire logic OP_READY, // Operation can be taken.
  input wire logic OP_DONE, // Operation finished.
  input wire logic [bitops_pkg::BUS_AW-1:0] BUS_ADDR, // Register address.
  input wire logic [7:0] BUS_WDATA, // Write data.
  input wire logic BUS_WR, // Write strobe.
  input wire logic BUS_RD, // Read strobe.
  input wire logic [7:0] BUS_RDATA // Read data.
);
  // ************************************************************
  // Operation timing
  // ************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  // An operation is taken when offered while the block is idle.
  logic take;
  assign take = OP_VALID && OP_READY;

  property p_push;
    take && OP_CODE == OP_PUSH |=> !OP_READY && !OP_DONE ##1 OP_DONE && OP_READY;
  endproperty
  a_push: assert property (p_push) else $error("push timing wrong");
  property p_pop;
    take && OP_CODE == OP_POP |-> ##1 !OP_READY ##1 OP_DONE;
  endproperty
  a_pop: assert property (p_pop) else $error("pop timing wrong");
  property p_io;
    take && OP_CODE inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} |=> OP_DONE && OP_READY;
  endproperty
  a_io: assert property (p_io) else $error("io bit timing wrong");
  property p_shift;
    take && OP_CODE inside {OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
      OP_ARITHMETIC_RIGHT_SHIFT} |=> OP_DONE;
  endproperty
  a_shift: assert property (p_shift) else $error("shift timing wrong");
  property p_rot;
    take && OP_CODE inside {OP_LEFT_ROTATE, OP_RIGHT_ROTATE} |-> ##1 OP_DONE && OP_READY;
  endproperty
  a_rot: assert property (p_rot) else $error("rotate timing wrong");
  property p_swap;
    take && OP_CODE == OP_NIBBLE_SWAP ##1 !OP_VALID |-> OP_DONE ##1 !OP_DONE;
  endproperty
  a_swap: assert property (p_swap) else $error("swap timing wrong");
  property p_tflag;
    take && OP_CODE inside {OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT}
      |=> OP_DONE;
  endproperty
  a_tflag: assert property (p_tflag) else $error("flag bit timing wrong");
  property p_carry;
    take && OP_CODE inside {OP_CARRY_SET, OP_CARRY_CLEAR} |=> OP_DONE && OP_READY;
  endproperty
  a_carry: assert property (p_carry) else $error("carry timing wrong");

  // ************************************************************
  // Handshake and read port
  // ************************************************************
  property p_ready_once;
    !OP_READY |=> OP_READY;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready low too long");
  property p_rdata_idle;
    !BUS_RD |=> BUS_RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");
endmodule

bind bitops_core bitops_core_chk chk (.CLK, .SRST, .OP_VALID, .OP_CODE, .OP_REG, .OP_BIT,
  .OP_READY, .OP_DONE, .BUS_ADDR, .BUS_WDATA, .BUS_WR, .BUS_RD, .BUS_RDATA);

// >>> test/tb.sv
// Self-checking bench for the bit, shift and stack execution block.
// Assumes the register map: registers at 0x00, I/O at 0x20, status at 0x40, stack at 0x60.
`timescale 1ns/1ps
module tb;
  import bitops_pkg::*;
  // ************************************************************
  // Stimulus and checks
  // ************************************************************
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic OP_VALID = 1'b0;
  op_t OP_CODE = OP_NOP;
  logic [4:0] OP_REG = 5'h00;
  logic [2:0] OP_BIT = 3'h0;
  logic OP_READY;
  logic OP_DONE;
  logic [6:0] BUS_ADDR = 7'h00;
  logic [7:0] BUS_WDATA = 8'h00;
  logic BUS_WR = 1'b0;
  logic BUS_RD = 1'b0;
  logic [7:0] BUS_RDATA;
  int err_count = 0;
  int compares = 0;

  // Clock of 100 ns period.
  always #50 CLK = ~CLK;

  bitops_core dut (.CLK(CLK), .SRST(SRST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_REG(OP_REG), .OP_BIT(OP_BIT), .OP_READY(OP_READY), .OP_DONE(OP_DONE),
    .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .BUS_WR(BUS_WR), .BUS_RD(BUS_RD),
    .BUS_RDATA(BUS_RDATA));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compares one byte.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One write cycle on the register port.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    BUS_WR <= 1'b1;
    BUS_ADDR <= a;
    BUS_WDATA <= d;
    @(posedge CLK);
    BUS_WR <= 1'b0;
  endtask

  // One read cycle; the data stand only in the following cycle.
  task automatic rd(input logic [6:0] a, input string what, input logic [7:0] exp);
    @(posedge CLK);
    BUS_RD <= 1'b1;
    BUS_ADDR <= a;
    @(posedge CLK);
    BUS_RD <= 1'b0;
    #1;
    chk(what, exp, BUS_RDATA);
  endtask

  // Offers one operation and checks how many cycles it takes to finish.
  task automatic op(input op_t c, input logic [4:0] r, input logic [2:0] b,
    input logic [7:0] cy);
    int n;
    @(posedge CLK);
    OP_VALID <= 1'b1;
    OP_CODE <= c;
    OP_REG <= r;
    OP_BIT <= b;
    @(posedge CLK);
    OP_VALID <= 1'b0;
    #1;
    n = 1;
    while (OP_DONE !== 1'b1)
    begin
      n++;
      if (n > 4)
      begin
        chk("op done", 8'h01, 8'h00);
        stop_test();
      end
      @(posedge CLK);
      #1;
    end
    chk("op cycles", cy, n[7:0]);
  endtask

  // Expected result and status after a shift or rotate.
  function automatic logic [15:0] shexp(input op_t c, input logic [7:0] v,
    input logic [7:0] st);
    logic [7:0] r;
    logic cy;
    logic n;
    logic ov;
    r = {st[0], v[7:1]};
    cy = v[0];
    if (c == OP_LOGICAL_RIGHT_SHIFT)
      r[7] = 1'b0;
    if (c == OP_ARITHMETIC_RIGHT_SHIFT)
      r[7] = v[7];
    if (c == OP_LOGICAL_LEFT_SHIFT || c == OP_LEFT_ROTATE)
    begin
      r = {v[6:0], st[0] & (c == OP_LEFT_ROTATE)};
      cy = v[7];
    end
    n = r[7];
    ov = n ^ cy;
    return {r, st[7:5], n ^ ov, ov, n, r == 8'h00, cy};
  endfunction

  // Every shift and rotate with both carry values.
  task automatic t_shift();
    op_t ops[5] = '{OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_LEFT_ROTATE,
      OP_RIGHT_ROTATE, OP_ARITHMETIC_RIGHT_SHIFT};
    logic [7:0] vals[2] = '{8'h80, 8'h01};
    logic [15:0] e;
    logic [7:0] st;
    foreach (ops[i])
      for (int j = 0; j < 2; j++)
      begin
        st = {7'h20, j[0]};
        e = shexp(ops[i], vals[j], st);
        wr(7'h03, vals[j]);
        wr(7'h40, st);
        op(ops[i], 5'h03, 3'h0, 8'h01);
        rd(7'h03, "shift result", e[15:8]);
        rd(7'h40, "shift flags", e[7:0]);
      end
    $display("shift test done");
  endtask

  // Push two bytes, pop them back in reverse order.
  task automatic t_stack();
    wr(7'h40, 8'h55);
    wr(7'h05, 8'ha5);
    wr(7'h06, 8'h5a);
    op(OP_PUSH, 5'h05, 3'h0, 8'h02);
    op(OP_PUSH, 5'h06, 3'h0, 8'h02);
    rd(7'h6f, "stack byte", 8'ha5);
    rd(7'h41, "stack pointer", 8'h0d);
    op(OP_POP, 5'h07, 3'h0, 8'h02);
    op(OP_POP, 5'h08, 3'h0, 8'h02);
    rd(7'h07, "first pop", 8'h5a);
    rd(7'h08, "second pop", 8'ha5);
    rd(7'h40, "stack flags", 8'h55);
    $display("stack test done");
  endtask

  // An operation offered while a push holds the block is ignored.
  task automatic t_refuse();
    wr(7'h0d, 8'h3c);
    @(posedge CLK);
    OP_VALID <= 1'b1;
    OP_CODE <= OP_PUSH;
    OP_REG <= 5'h0d;
    @(posedge CLK);
    OP_CODE <= OP_NIBBLE_SWAP;
    @(posedge CLK);
    OP_VALID <= 1'b0;
    rd(7'h0d, "refused swap", 8'h3c);
    rd(7'h6f, "pushed byte", 8'h3c);
    rd(7'h41, "pointer after push", 8'h0e);
    $display("refuse test done");
  endtask

  // Bit set and clear on an I/O register, including the top bit.
  task automatic t_io();
    wr(7'h24, 8'h5a);
    wr(7'h40, 8'h2a);
    op(OP_IO_BIT_SET, 5'h04, 3'h0, 8'h01);
    rd(7'h24, "io set", 8'h5b);
    op(OP_IO_BIT_CLEAR, 5'h04, 3'h6, 8'h01);
    rd(7'h24, "io clear", 8'h1b);
    op(OP_IO_BIT_SET, 5'h04, 3'h7, 8'h01);
    rd(7'h24, "io top set", 8'h9b);
    rd(7'h40, "io flags", 8'h2a);
    $display("io test done");
  endtask

  // Swap, transfer flag moves and carry forcing.
  task automatic t_misc();
    wr(7'h0c, 8'h3c);
    wr(7'h40, 8'h5f);
    op(OP_NIBBLE_SWAP, 5'h0c, 3'h0, 8'h01);
    rd(7'h0c, "swap result", 8'hc3);
    rd(7'h40, "swap flags", 8'h5f);
    wr(7'h09, 8'h10);
    wr(7'h40, 8'h1f);
    op(OP_BIT_TO_TRANSFER_FLAG, 5'h09, 3'h4, 8'h01);
    rd(7'h40, "transfer set", 8'h5f);
    op(OP_TRANSFER_FLAG_TO_BIT, 5'h0a, 3'h1, 8'h01);
    rd(7'h0a, "bit load", 8'h02);
    op(OP_BIT_TO_TRANSFER_FLAG, 5'h09, 3'h0, 8'h01);
    rd(7'h40, "transfer clear", 8'h1f);
    op(OP_TRANSFER_FLAG_TO_BIT, 5'h0a, 3'h1, 8'h01);
    rd(7'h0a, "bit clear load", 8'h00);
    rd(7'h40, "bit load flags", 8'h1f);
    wr(7'h40, 8'h5e);
    op(OP_CARRY_SET, 5'h00, 3'h0, 8'h01);
    rd(7'h40, "carry set", 8'h5f);
    op(OP_CARRY_CLEAR, 5'h00, 3'h0, 8'h01);
    rd(7'h40, "carry clear", 8'h5e);
    op(OP_STATUS_FLAG_SET, 5'h00, 3'h7, 8'h01);
    rd(7'h40, "flag set", 8'hde);
    op(OP_STATUS_FLAG_CLEAR, 5'h00, 3'h4, 8'h01);
    rd(7'h40, "flag clear", 8'hce);
    op(OP_NOP, 5'h0c, 3'h0, 8'h01);
    rd(7'h0c, "no-op keeps register", 8'hc3);
    rd(7'h40, "no-op keeps flags", 8'hce);
    $display("misc test done");
  endtask

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge CLK);
    SRST <= 1'b0;
    rd(7'h41, "reset stack pointer", 8'h0f);
    rd(7'h42, "reset exec state", 8'h00);
    rd(7'h70, "unmapped read", 8'h00);
    t_shift();
    t_stack();
    t_refuse();
    t_io();
    t_misc();
    stop_test();
  end
endmodule

// >>> verilog/bitops_core.sv
// Execution block for stack, I/O bit, shift, rotate, swap and flag operations.
// Assumes one operation is offered at a time with OP_VALID and held off
// while OP_READY is low; register access comes over a simple strobe port.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps

module bitops_core
(
  input wire logic CLK, // Core clock, 10 MHz.
  input wire logic SRST, // Synchronous reset, active high.
  input wire logic OP_VALID, // Operation offered.
  input wire bitops_pkg::op_t OP_CODE, // Operation code.
  input wire logic [bitops_pkg::REG_AW-1:0] OP_REG, // Register or I/O index.
  input wire logic [bitops_pkg::BIT_AW-1:0] OP_BIT, // Bit or flag number.
  output logic OP_READY, // Operation can be taken.
  output logic OP_DONE, // Operation finished last cycle.
  input wire logic [bitops_pkg::BUS_AW-1:0] BUS_ADDR, // Register address.
  input wire logic [7:0] BUS_WDATA, // Write data.
  input wire logic BUS_WR, // Write strobe.
  input wire logic BUS_RD, // Read strobe.
  output logic [7:0] BUS_RDATA // Read data, one cycle after the strobe.
);
  import bitops_pkg::*;

  // ************************************************************
  // Storage and state
  // ************************************************************
  logic [7:0] gpr_q [0:31];
  logic [7:0] io_q [0:31];
  logic [7:0] stack_q [0:(1<<SP_W)-1];
  logic [7:0] status_register_q;
  logic [SP_W-1:0] sp_q;
  state_t state_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic [REG_AW-1:0] pop_reg_q;

  logic take;
  logic [7:0] src_val;
  logic [7:0] sh_result;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  logic sh_s;
  logic is_shift;
  logic [1:0] bus_area;
  logic [REG_AW-1:0] bus_idx;

  // Mask with a single bit set at the given position.
  function automatic logic [7:0] bit_mask(input logic [BIT_AW-1:0] pos);
    bit_mask = 8'h01 << pos;
  endfunction

  // Operation is taken only while no two-cycle operation is pending.
  assign OP_READY = (state_q == ST_IDLE);
  assign take = OP_VALID && OP_READY;
  assign src_val = gpr_q[OP_REG];
  assign OP_DONE = done_q;
  assign BUS_RDATA = rdata_q;
  assign bus_area = BUS_ADDR[BUS_AW-1:REG_AW];
  assign bus_idx = BUS_ADDR[REG_AW-1:0];

  // Shift-group operations go through the shift unit.
  always_comb
  begin
    case (OP_CODE)
      OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT, OP_LEFT_ROTATE,
      OP_RIGHT_ROTATE, OP_ARITHMETIC_RIGHT_SHIFT, OP_NIBBLE_SWAP:
        is_shift = 1'b1;
      default:
        is_shift = 1'b0;
    endcase
  end

  shift_unit u_shift
  (
    .op(OP_CODE),
    .value(src_val),
    .carry_in(status_register_q[FLAG_C]),
    .result(sh_result),
    .carry_out(sh_c),
    .zero_out(sh_z),
    .neg_out(sh_n),
    .ovf_out(sh_v),
    .sign_out(sh_s)
  );

  // ************************************************************
  // Sequencing
  // ************************************************************

  // Push and pop hold the block for a second cycle.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      state_q <= ST_IDLE;
      pop_reg_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (take && OP_CODE == OP_PUSH)
          begin
            state_q <= ST_PUSH2;
          end
          else if (take && OP_CODE == OP_POP)
          begin
            state_q <= ST_POP2;
            pop_reg_q <= OP_REG;
          end
        end
        ST_PUSH2, ST_POP2:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Completion pulse the cycle after an operation's last edge.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (take && OP_CODE != OP_PUSH && OP_CODE != OP_POP)
        || state_q != ST_IDLE;
    end
  end

  // ************************************************************
  // Stack
  // ************************************************************

  // Stack pointer: push decrements after storing, pop increments before loading.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      sp_q <= SP_RESET;
    end
    else if (state_q == ST_PUSH2)
    begin
      sp_q <= sp_q - SP_ONE;
    end
    else if (take && OP_CODE == OP_POP)
    begin
      sp_q <= sp_q + SP_ONE;
    end
    else if (BUS_WR && bus_area == AREA_CTL && bus_idx == CTL_SP)
    begin
      sp_q <= BUS_WDATA[SP_W-1:0];
    end
  end

  // Stack storage: first cycle of a push writes at the pointer.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      for (int i = 0; i < (1 << SP_W); i++)
        stack_q[i] <= BYTE_ZERO;
    end
    else if (take && OP_CODE == OP_PUSH)
    begin
      stack_q[sp_q] <= src_val;
    end
    else if (BUS_WR && bus_area == AREA_STACK)
    begin
      stack_q[bus_idx[SP_W-1:0]] <= BUS_WDATA;
    end
  end

  // ************************************************************
  // General-purpose registers
  // ************************************************************

  // Operation results win over a register-port write in the same cycle.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      for (int i = 0; i < 32; i++)
        gpr_q[i] <= BYTE_ZERO;
    end
    else if (state_q == ST_POP2)
    begin
      gpr_q[pop_reg_q] <= stack_q[sp_q];
    end
    else if (take && is_shift)
    begin
      gpr_q[OP_REG] <= sh_result;
    end
    else if (take && OP_CODE == OP_TRANSFER_FLAG_TO_BIT)
    begin
      // Only the chosen bit takes T.
      if (status_register_q[FLAG_T])
        gpr_q[OP_REG] <= src_val | bit_mask(OP_BIT);
      else
        gpr_q[OP_REG] <= src_val & ~bit_mask(OP_BIT);
    end
    else if (BUS_WR && bus_area == AREA_GPR)
    begin
      gpr_q[bus_idx] <= BUS_WDATA;
    end
  end

  // ************************************************************
  // I/O registers
  // ************************************************************

  // Read-modify-write of one I/O bit; other bits are kept.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      for (int i = 0; i < 32; i++)
        io_q[i] <= BYTE_ZERO;
    end
    else if (take && OP_CODE == OP_IO_BIT_SET)
    begin
      io_q[OP_REG] <= io_q[OP_REG] | bit_mask(OP_BIT);
    end
    else if (take && OP_CODE == OP_IO_BIT_CLEAR)
    begin
      io_q[OP_REG] <= io_q[OP_REG] & ~bit_mask(OP_BIT);
    end
    else if (BUS_WR && bus_area == AREA_IO)
    begin
      io_q[bus_idx] <= BUS_WDATA;
    end
  end

  // ************************************************************
  // Status register
  // ************************************************************

  // Only shift-group and flag operations touch the flags.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      status_register_q <= BYTE_ZERO;
    end
    else if (take && is_shift && OP_CODE != OP_NIBBLE_SWAP)
    begin
      // Shifts and rotates update Z, C, N, V and S together.
      status_register_q[FLAG_C] <= sh_c;
      status_register_q[FLAG_Z] <= sh_z;
      status_register_q[FLAG_N] <= sh_n;
      status_register_q[FLAG_V] <= sh_v;
      status_register_q[FLAG_S] <= sh_s;
    end
    else if (take && OP_CODE == OP_STATUS_FLAG_SET)
    begin
      status_register_q[OP_BIT] <= 1'b1;
    end
    else if (take && OP_CODE == OP_STATUS_FLAG_CLEAR)
    begin
      status_register_q[OP_BIT] <= 1'b0;
    end
    else if (take && OP_CODE == OP_BIT_TO_TRANSFER_FLAG)
    begin
      status_register_q[FLAG_T] <= src_val[OP_BIT];
    end
    else if (take && OP_CODE == OP_CARRY_SET)
    begin
      status_register_q[FLAG_C] <= 1'b1;
    end
    else if (take && OP_CODE == OP_CARRY_CLEAR)
    begin
      status_register_q[FLAG_C] <= 1'b0;
    end
    else if (BUS_WR && bus_area == AREA_CTL && bus_idx == CTL_STATUS)
    begin
      status_register_q <= BUS_WDATA;
    end
  end

  // ************************************************************
  // Register port read
  // ************************************************************

  // Read data stand for one cycle after the strobe, zero otherwise.
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      rdata_q <= BYTE_ZERO;
    end
    else if (BUS_RD)
    begin
      case (bus_area)
        AREA_GPR:
          rdata_q <= gpr_q[bus_idx];
        AREA_IO:
          rdata_q <= io_q[bus_idx];
        AREA_STACK:
          rdata_q <= (bus_idx[REG_AW-1:SP_W] == 1'b0)
            ? stack_q[bus_idx[SP_W-1:0]] : BYTE_ZERO;
        AREA_CTL:
        begin
          case (bus_idx)
            CTL_STATUS:
              rdata_q <= status_register_q;
            CTL_SP:
              rdata_q <= {4'h0, sp_q};
            CTL_EXEC:
              rdata_q <= {6'h00, state_q};
            default:
              rdata_q <= BYTE_ZERO;
          endcase
        end
        default:
          rdata_q <= BYTE_ZERO;
      endcase
    end
    else
    begin
      rdata_q <= BYTE_ZERO;
    end
  end

endmodule

// >>> verilog/bitops_pkg.sv
// Shared constants and types for the bit, shift and stack execution block.
// Assumes a single 10 MHz core clock and a synchronous active-high reset.
package bitops_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int DATA_W = 8;
  localparam int REG_AW = 5;
  localparam int BIT_AW = 3;
  localparam int SP_W = 4;
  localparam int BUS_AW = 7;
  localparam logic [SP_W-1:0] SP_RESET = 4'hf;
  localparam logic [SP_W-1:0] SP_ONE = 4'h1;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // ************************************************************
  // Status register bit positions
  // ************************************************************
  localparam logic [BIT_AW-1:0] FLAG_C = 3'h0;
  localparam logic [BIT_AW-1:0] FLAG_Z = 3'h1;
  localparam logic [BIT_AW-1:0] FLAG_N = 3'h2;
  localparam logic [BIT_AW-1:0] FLAG_V = 3'h3;
  localparam logic [BIT_AW-1:0] FLAG_S = 3'h4;
  localparam logic [BIT_AW-1:0] FLAG_T = 3'h6;

  // ************************************************************
  // Register port map
  // ************************************************************
  localparam logic [1:0] AREA_GPR = 2'h0;
  localparam logic [1:0] AREA_IO = 2'h1;
  localparam logic [1:0] AREA_CTL = 2'h2;
  localparam logic [1:0] AREA_STACK = 2'h3;
  localparam logic [REG_AW-1:0] CTL_STATUS = 5'h00;
  localparam logic [REG_AW-1:0] CTL_SP = 5'h01;
  localparam logic [REG_AW-1:0] CTL_EXEC = 5'h02;

  // ************************************************************
  // Operation codes
  // ************************************************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_PUSH = 5'h01,
    OP_POP = 5'h02,
    OP_IO_BIT_SET = 5'h03,
    OP_IO_BIT_CLEAR = 5'h04,
    OP_LOGICAL_LEFT_SHIFT = 5'h05,
    OP_LOGICAL_RIGHT_SHIFT = 5'h06,
    OP_LEFT_ROTATE = 5'h07,
    OP_RIGHT_ROTATE = 5'h08,
    OP_ARITHMETIC_RIGHT_SHIFT = 5'h09,
    OP_NIBBLE_SWAP = 5'h0a,
    OP_STATUS_FLAG_SET = 5'h0b,
    OP_STATUS_FLAG_CLEAR = 5'h0c,
    OP_BIT_TO_TRANSFER_FLAG = 5'h0d,
    OP_TRANSFER_FLAG_TO_BIT = 5'h0e,
    OP_CARRY_SET = 5'h0f,
    OP_CARRY_CLEAR = 5'h10
  } op_t;

  // Execution states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH2 = 2'b01,
    ST_POP2 = 2'b10
  } state_t;

endpackage

// >>> verilog/shift_unit.sv
// Combinational shift, rotate and nibble swap unit with flag results.
// Assumes the caller only uses its outputs for the shift-group operations.
`timescale 1ns/1ps
module shift_unit
(
  input wire bitops_pkg::op_t op, // Operation being executed.
  input wire logic [7:0] value, // Destination register contents.
  input wire logic carry_in, // Current carry flag.
  output logic [7:0] result, // New destination value.
  output logic carry_out, // New carry flag.
  output logic zero_out, // New zero flag.
  output logic neg_out, // New negative flag.
  output logic ovf_out, // New overflow flag.
  output logic sign_out // New sign flag.
);
  import bitops_pkg::*;

  // ************************************************************
  // Datapath
  // ************************************************************

  // Result and carry for each shift kind.
  always_comb
  begin
    result = value;
    carry_out = carry_in;
    case (op)
      OP_LOGICAL_LEFT_SHIFT:
      begin
        result = {value[6:0], 1'b0};
        carry_out = value[7];
      end
      OP_LOGICAL_RIGHT_SHIFT:
      begin
        result = {1'b0, value[7:1]};
        carry_out = value[0];
      end
      OP_LEFT_ROTATE:
      begin
        result = {value[6:0], carry_in};
        carry_out = value[7];
      end
      OP_RIGHT_ROTATE:
      begin
        result = {carry_in, value[7:1]};
        carry_out = value[0];
      end
      OP_ARITHMETIC_RIGHT_SHIFT:
      begin
        result = {value[7], value[7:1]};
        carry_out = value[0];
      end
      OP_NIBBLE_SWAP:
      begin
        result = {value[3:0], value[7:4]};
      end
      default:
      begin
        result = value;
        carry_out = carry_in;
      end
    endcase
  end

  // Flags follow from the result; overflow is negative xor carry.
  assign zero_out = (result == BYTE_ZERO);
  assign neg_out = result[7];
  assign ovf_out = neg_out ^ carry_out;
  assign sign_out = neg_out ^ ovf_out;

endmodule
